/* design/link_sample_if.sv */
/*
  Carrier for synchronised pin levels and their edge pulses.
  Assumes one producer (pin_sync) and one consumer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface link_sample_if #(
  parameter int unsigned WIDTH = 1
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  modport source (
    output level,
    output rise,
    output fall
  );

  modport sink (
    input level,
    input rise,
    input fall
  );
endinterface : link_sample_if

`default_nettype wire

/* design/mdio_mmd_pkg.sv */
/*
  Shared constants for the management frame slave: field lengths,
  opcodes, the accepted device type, reset values and the frame states.
  Assumes a SystemVerilog-2012 tool flow; imported whole by the modules.
*/
`default_nettype none

package mdio_mmd_pkg;

  // Frame layout
  localparam int unsigned FRAME_BITS = 64;
  localparam int unsigned PREAMBLE_LEN = 32;
  localparam int unsigned COUNT_W = 4;
  localparam int unsigned ONES_W = 6;
  localparam int unsigned PORT_BITS = 5;
  localparam int unsigned DEVICE_BITS = 5;
  localparam int unsigned DATA_BITS = 16;
  localparam logic [ONES_W-1:0] PREAMBLE_BITS = 6'h20;
  localparam logic [ONES_W-1:0] ONES_CLEAR = 6'h00;
  localparam logic [ONES_W-1:0] ONES_FIRST = 6'h01;

  // Last index of each field, counted down to zero
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;
  localparam logic [COUNT_W-1:0] OPCODE_LAST = 4'h1;
  localparam logic [COUNT_W-1:0] PORT_LAST = 4'h4;
  localparam logic [COUNT_W-1:0] DEVICE_LAST = 4'h4;
  localparam logic [COUNT_W-1:0] TURN_LAST = 4'h1;
  localparam logic [COUNT_W-1:0] DATA_LAST = 4'hF;

  // Opcodes
  localparam logic [1:0] OP_SET_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;

  // Only this device type is answered
  localparam logic [DEVICE_BITS-1:0] DEVICE_TYPE_SELECT = 5'h01;

  // Reset values
  localparam logic [DATA_BITS-1:0] RESET_WORD = 16'h0000;
  localparam logic [PORT_BITS-1:0] RESET_PORT = 5'h00;

  // Positions on the sampled line bus
  localparam int unsigned LINE_PINS = 2;
  localparam int unsigned LINE_MDC = 1;
  localparam int unsigned LINE_MDIO = 0;

  typedef enum logic [5:0] {
    ST_HUNT   = 6'b00_0001,
    ST_OPCODE = 6'b00_0010,
    ST_PORT   = 6'b00_0100,
    ST_DEVICE = 6'b00_1000,
    ST_TURN   = 6'b01_0000,
    ST_DATA   = 6'b10_0000
  } frame_state_e;

endpackage : mdio_mmd_pkg

`default_nettype wire

/* design/mdio_mmd_port.sv */
/*
  Management frame slave: decodes address, write, read and
  read-with-increment frames on the MDC/MDIO pair and answers reads.
  Assumes mclk_i is many times faster than MDC and that the pad
  resolves the MDIO wire from mdio_o and mdio_oe_o.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Whole frames are decoded by hardware with no software help.
// - Reply word is taken at device-type end, before turnaround, and shifted out.
// - A one-cycle done pulse marks each complete accepted frame.
// - Mismatched port or device type: frame dropped, no store, no drive.
// - Optional match pulse after a matching port and device-type pair.
// - Frame is 32 preamble ones plus a 32-bit command body.
// - All fields shift most significant bit first.
// - Line is released between frames; enable low when idle.
// - Two zeros after the preamble open the frame.
// - Opcode 00 latches the address; 01 writes data to it.
// - Opcodes 11 and 10 return data; software steps the address.
// - Reads: first turnaround undriven, second driven zero, then 16 bits.
// - Port address is five bits, from pins or software.
// - Device-type field is five bits; only type 1 answers.
// - Address/data field is exactly sixteen bits.
module mdio_mmd_port
  import mdio_mmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic [PORT_BITS-1:0] port_address_pins_i,
  input wire logic [PORT_BITS-1:0] port_address_sw_i,
  input wire logic port_address_use_pins_i,
  input wire logic match_event_enable_i,
  input wire logic [DATA_BITS-1:0] reply_data_i,
  input wire logic address_step_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic [DATA_BITS-1:0] captured_register_address_o,
  output logic [DATA_BITS-1:0] write_data_o,
  output logic write_strobe_o,
  output logic frame_done_o,
  output logic [1:0] frame_opcode_o,
  output logic match_event_o,
  output logic frame_active_o
);

  function automatic logic is_read_op(input logic [1:0] op);
    is_read_op = (op == OP_READ) || (op == OP_READ_INC);
  endfunction : is_read_op

  link_sample_if #(.WIDTH(LINE_PINS)) line_bus ();
  link_sample_if #(.WIDTH(PORT_BITS)) strap_bus ();

  pin_sync #(.WIDTH(LINE_PINS)) line_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pins_i({mdc_i, mdio_i}),
    .sample(line_bus.source)
  );

  pin_sync #(.WIDTH(PORT_BITS)) strap_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pins_i(port_address_pins_i),
    .sample(strap_bus.source)
  );

  frame_state_e state;
  frame_state_e next_state;
  logic [COUNT_W-1:0] bit_count;
  logic [COUNT_W-1:0] next_count;
  logic [ONES_W-1:0] ones_count;
  logic zero_after_pre;
  logic [1:0] opcode;
  logic port_ok;
  logic [DATA_BITS-1:0] rx_shift;
  logic [DATA_BITS-1:0] tx_shift;

  // Bit timing taken from the synchronised MDC rise
  wire bit_tick = line_bus.rise[LINE_MDC];
  wire line_bit = line_bus.level[LINE_MDIO];

  // Frame start hunting
  wire preamble_full = (ones_count == PREAMBLE_BITS);
  wire start_seen = bit_tick & ~line_bit & zero_after_pre;
  wire [ONES_W-1:0] ones_step = (ones_count == PREAMBLE_BITS) ? ones_count
                                : ones_count + ONES_FIRST;
  wire [ONES_W-1:0] next_ones = line_bit ? ones_step : ONES_CLEAR;

  // Field decode
  wire [DATA_BITS-1:0] shifted = {rx_shift[DATA_BITS-2:0], line_bit};
  wire [PORT_BITS-1:0] field5 = shifted[PORT_BITS-1:0];
  wire [PORT_BITS-1:0] expected_port = port_address_use_pins_i ? strap_bus.level
                                       : port_address_sw_i;
  wire field_end = bit_tick & (bit_count == COUNT_ZERO) & ~start_seen;
  wire in_frame = (state != ST_HUNT);
  wire opcode_end = field_end & (state == ST_OPCODE);
  wire port_end = field_end & (state == ST_PORT);
  wire device_end = field_end & (state == ST_DEVICE);
  wire data_end = field_end & (state == ST_DATA);
  wire device_ok = (field5 == DEVICE_TYPE_SELECT);
  wire frame_match = port_ok & device_ok;
  wire read_frame = is_read_op(opcode);

  // Line drive points for reads
  wire live_tick = bit_tick & ~start_seen;
  wire turn_first_end = live_tick & (state == ST_TURN) & (bit_count == TURN_LAST)
                        & read_frame;
  wire shift_out = live_tick & read_frame
                   & (((state == ST_TURN) & (bit_count == COUNT_ZERO))
                   | ((state == ST_DATA) & (bit_count != COUNT_ZERO)));
  wire release_line = data_end | start_seen | (device_end & ~frame_match);

  // Frame sequencing
  always_comb
  begin
    next_state = state;
    next_count = bit_count;
    if (start_seen)
    begin
      next_state = ST_OPCODE;
      next_count = OPCODE_LAST;
    end
    else if (bit_tick && in_frame)
    begin
      if (bit_count != COUNT_ZERO)
      begin
        next_count = bit_count - COUNT_W'(1);
      end
      else
      begin
        unique case (state)
          ST_HUNT:
          begin
            next_state = ST_HUNT;
          end
          ST_OPCODE:
          begin
            next_state = ST_PORT;
            next_count = PORT_LAST;
          end
          ST_PORT:
          begin
            next_state = ST_DEVICE;
            next_count = DEVICE_LAST;
          end
          ST_DEVICE:
          begin
            next_state = frame_match ? ST_TURN : ST_HUNT;
            next_count = TURN_LAST;
          end
          ST_TURN:
          begin
            next_state = ST_DATA;
            next_count = DATA_LAST;
          end
          ST_DATA:
          begin
            next_state = ST_HUNT;
          end
          default:
          begin
            next_state = ST_HUNT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_HUNT;
      bit_count <= COUNT_ZERO;
      frame_active_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bit_count <= next_count;
      frame_active_o <= (next_state != ST_HUNT);
    end
  end

  // Preamble counter and start detector
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ones_count <= ONES_CLEAR;
      zero_after_pre <= 1'b0;
    end
    else if (bit_tick)
    begin
      ones_count <= next_ones;
      zero_after_pre <= ~line_bit & preamble_full & ~zero_after_pre;
    end
  end

  // Receive shift register and header fields
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_shift <= RESET_WORD;
      opcode <= OP_SET_ADDRESS;
      port_ok <= 1'b0;
    end
    else
    begin
      if (bit_tick)
      begin
        rx_shift <= shifted;
      end
      if (opcode_end)
      begin
        opcode <= shifted[1:0];
      end
      if (port_end)
      begin
        port_ok <= (field5 == expected_port);
      end
    end
  end

  // Completed frame results
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      captured_register_address_o <= RESET_WORD;
      write_data_o <= RESET_WORD;
      write_strobe_o <= 1'b0;
      frame_done_o <= 1'b0;
      frame_opcode_o <= OP_SET_ADDRESS;
      match_event_o <= 1'b0;
    end
    else
    begin
      write_strobe_o <= data_end & (opcode == OP_WRITE);
      frame_done_o <= data_end;
      match_event_o <= device_end & frame_match & match_event_enable_i;
      if (data_end)
      begin
        frame_opcode_o <= opcode;
      end
      if (data_end && (opcode == OP_WRITE))
      begin
        write_data_o <= shifted;
      end
      // Hardware latch beats a software step in the same cycle
      if (data_end && (opcode == OP_SET_ADDRESS))
      begin
        captured_register_address_o <= shifted;
      end
      else if (address_step_i)
      begin
        captured_register_address_o <= captured_register_address_o
                                       + DATA_BITS'(1);
      end
    end
  end

  // Reply serialiser and line driver
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_shift <= RESET_WORD;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end
    else
    begin
      if (device_end && frame_match && read_frame)
      begin
        tx_shift <= reply_data_i;
      end
      else if (shift_out)
      begin
        tx_shift <= {tx_shift[DATA_BITS-2:0], 1'b0};
      end
      if (release_line)
      begin
        mdio_oe_o <= 1'b0;
        mdio_o <= 1'b0;
      end
      else if (turn_first_end)
      begin
        mdio_oe_o <= 1'b1;
        mdio_o <= 1'b0;
      end
      else if (shift_out)
      begin
        mdio_o <= tx_shift[DATA_BITS-1];
      end
    end
  end

endmodule : mdio_mmd_port

`default_nettype wire

/* design/pin_sync.sv */
/*
  Three-stage synchroniser for asynchronous pins with an agree filter
  and edge pulses. Assumes pins are slow against clk_i (MDC at 400 ns).
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pins_i,
  link_sample_if.source sample
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] stable;
  wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire [WIDTH-1:0] next_stable = (agree & stage3) | (~agree & stable);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      stable <= '0;
    end
    else
    begin
      stage1 <= pins_i;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
    end
  end

  // Pulses lead the level by one cycle so users act on the same edge
  assign sample.level = stable;
  assign sample.rise = next_stable & ~stable;
  assign sample.fall = ~next_stable & stable;

endmodule : pin_sync

`default_nettype wire

/* dv/mdio_host_model.sv */
/*
  Station host model: clocks and sends one frame per call.
  Assumes a pull-up on the line; the clock stays low between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module mdio_host_model (
  output logic mdc_o,
  output logic drive_o,
  output logic data_o,
  input wire logic line_i
);
  initial
  begin
    mdc_o = 1'b0;
    drive_o = 1'b0;
    data_o = 1'b1;
  end

  task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
    input logic [15:0] data, input int len, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b00, op, port, dev, 2'b10, data};
    rd = 16'h0000;
    for (int i = 0; i < len; i++)
    begin
      drive_o = !(op[1] && i >= 46);
      data_o = bits[63-i];
      #200 mdc_o = 1'b1;
      if (i >= 48)
        rd = {rd[14:0], line_i};
      #200 mdc_o = 1'b0;
    end
    drive_o = 1'b0;
  endtask : frame
endmodule : mdio_host_model

`default_nettype wire

/* dv/mdio_mmd_port_properties.sv */
/*
  Checker for the frame slave, bound to its top module.
  Assumes the host model clocks the link at 400 ns and mclk at 50 ns.
*/
`timescale 1ns/1ps
`default_nettype none

module mdio_mmd_port_properties
  import mdio_mmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic match_event_enable_i,
  input wire logic address_step_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic [DATA_BITS-1:0] captured_register_address_o,
  input wire logic write_strobe_o,
  input wire logic frame_done_o,
  input wire logic [1:0] frame_opcode_o,
  input wire logic match_event_o,
  input wire logic frame_active_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Seventeen link bits of drive, then a read frame ends
  sequence drive_end;
    ##[128:144] $fell(mdio_oe_o) ##[0:1] (frame_done_o && frame_opcode_o[1]);
  endsequence

  idle_low_a: assert property (!mdio_oe_o |-> !mdio_o)
    else $error("line value while released");
  turn_zero_a: assert property ($rose(mdio_oe_o) |-> (mdio_oe_o && !mdio_o) [*6])
    else $error("turnaround bit not zero");
  reply_span_a: assert property ($rose(mdio_oe_o) |-> drive_end)
    else $error("reply drive length wrong");
  drive_active_a: assert property ($rose(mdio_oe_o) |-> frame_active_o)
    else $error("drive outside a frame");
  done_pulse_a: assert property (frame_done_o |=> !frame_done_o)
    else $error("done longer than one cycle");
  done_active_a: assert property (frame_done_o |-> $past(frame_active_o))
    else $error("done without a frame");
  strobe_write_a: assert property (write_strobe_o |->
    frame_done_o && frame_opcode_o == OP_WRITE)
    else $error("strobe without write frame");
  match_gate_a: assert property (match_event_o |-> match_event_enable_i)
    else $error("match event while disabled");
  step_inc_a: assert property (address_step_i |=> frame_done_o ||
    captured_register_address_o == $past(captured_register_address_o) + 16'h0001)
    else $error("address step lost");
endmodule : mdio_mmd_port_properties

bind mdio_mmd_port mdio_mmd_port_properties mdio_mmd_port_properties_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .match_event_enable_i(match_event_enable_i),
  .address_step_i(address_step_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .captured_register_address_o(captured_register_address_o),
  .write_strobe_o(write_strobe_o), .frame_done_o(frame_done_o),
  .frame_opcode_o(frame_opcode_o), .match_event_o(match_event_o),
  .frame_active_o(frame_active_o)
);

`default_nettype wire

/* dv/tb_top.sv */
/*
  Self-checking bench: host model on the link, reference model in queues.
  Assumes package, design, checker and host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import mdio_mmd_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mdc, host_oe, host_d, line, use_pins, m_en, step, dout, doe, wstb, done, match, active;
  logic [4:0] pins, sw;
  logic [15:0] reply, cap, wdat;
  logic [1:0] op_o;
  logic [15:0] seed = 16'hB7F3;
  logic [15:0] rdq[$];
  int err_count, check_count, cycles, done_n, match_n, exp_addr, exp_wdat, exp_done, exp_match;
  int wstb_n, exp_wstb;

  always #25 mclk_i = ~mclk_i;
  // Pull-up when nobody drives
  assign line = doe ? dout : host_oe ? host_d : 1'b1;

  mdio_host_model mdio_host_model_i (.mdc_o(mdc), .drive_o(host_oe), .data_o(host_d),
    .line_i(line));
  mdio_mmd_port mdio_mmd_port_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .mdc_i(mdc), .mdio_i(line),
    .port_address_pins_i(pins), .port_address_sw_i(sw), .port_address_use_pins_i(use_pins),
    .match_event_enable_i(m_en), .reply_data_i(reply), .address_step_i(step),
    .mdio_o(dout), .mdio_oe_o(doe), .captured_register_address_o(cap),
    .write_data_o(wdat), .write_strobe_o(wstb), .frame_done_o(done),
    .frame_opcode_o(op_o), .match_event_o(match), .frame_active_o(active)
  );

  function automatic logic [15:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : lfsr

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic run(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
    input int len);
    logic [15:0] d;
    logic [15:0] rd;
    logic hit;
    d = lfsr();
    hit = port == (use_pins ? pins : sw) && dev == DEVICE_TYPE_SELECT && len == 64;
    @(negedge mclk_i);
    reply = d;
    mdio_host_model_i.frame(op, port, dev, d, len, rd);
    repeat (12) @(negedge mclk_i);
    if (hit)
    begin
      exp_done++;
      exp_match += int'(m_en);
      if (op == OP_SET_ADDRESS)
        exp_addr = d;
      else if (op == OP_WRITE)
      begin
        exp_wdat = d;
        exp_wstb++;
      end
      else
        rdq.push_back(d);
    end
    if (hit && op[1])
      chk(rdq.pop_front(), rd);
    if (hit)
      chk({14'h0000, op}, {14'h0000, op_o});
    chk(16'(exp_addr), cap);
    chk(16'(exp_wdat), wdat);
    chk(16'(exp_done), 16'(done_n));
    chk(16'(exp_match), 16'(match_n));
    chk(16'(exp_wstb), 16'(wstb_n));
    $display("test op=%0d port=%0d dev=%0d bits=%0d ended", op, port, dev, len);
  endtask : run

  always @(posedge mclk_i)
  begin
    cycles++;
    if (done === 1'b1)
      done_n++;
    if (match === 1'b1)
      match_n++;
    if (wstb === 1'b1)
      wstb_n++;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    pins = 5'h13;
    sw = 5'h0A;
    use_pins = 1'b0;
    m_en = 1'b1;
    step = 1'b0;
    reply = 16'h0000;
    repeat (3) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    for (int k = 0; k < 4; k++)
      run(2'(k), sw, 5'h01, 64);
    step = 1'b1;
    @(negedge mclk_i);
    step = 1'b0;
    exp_addr++;
    @(negedge mclk_i);
    chk(16'(exp_addr), cap);
    $display("test address step ended");
    run(2'h3, sw ^ 5'h01, 5'h01, 64);
    run(2'h1, sw, 5'h02, 64);
    use_pins = 1'b1;
    run(2'h1, sw, 5'h01, 64);
    run(2'h2, pins, 5'h01, 64);
    m_en = 1'b0;
    run(2'h0, pins, 5'h01, 44);
    run(2'h3, pins, 5'h01, 64);
    m_en = 1'b1;
    repeat (4) run(seed[1:0], pins, 5'h01, 64);
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
